// ### src/undercurrent_inrush_protection.sv
// Phase undercurrent protection with inrush restraint, top level
//
// Notes on behaviour
// - Any phase below threshold raises undercurrent
// - Runs only when enabled and mode on
// - Pickup after condition persists pickup delay
// - Trip after pickup held trip delay
// - Pickup held through drop-out delay
// - Clears only above threshold times ratio
// - Selected external block suppresses pickup
// - Zero current blocks when all phases low
// - Block held recovery time after zero
// - Trip is pulse when mapped to relay
// - Per-phase pickup event counters
// - Total pickup counter and trip counter
// - Inrush when second harmonic exceeds percentage
// - Inrush block output off above maximum current
// - Inrush held fixed 0,20 s after release
// - Inrush block limited to 5,00 s
// - Inrush output blocks overcurrent functions
// - Inrush evaluated for each phase separately
// - Inrush events counted
`timescale 1ns/1ps
module undercurrent_inrush_protection import uc_pkg::*; #(
    parameter int TICK_CYCLES = CYCLES_PER_MS,
    parameter int CNT_W = CNT_W_DEF,
    parameter int TRIP_PULSE_CYCLES = TRIP_PULSE_DEF
) (
    input wire logic clock, // 20 MHz function clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [2:0][CUR_W-1:0] phase_mag, // Phase magnitudes, 0,01 In
    input wire logic [2:0][PCT_W-1:0] h2_pct, // Second harmonic, percent
    input wire logic function_enable, // Function enabled
    input wire logic operate_on, // Group operate mode on
    input wire logic [CUR_W-1:0] pickup_thr, // Pickup value, 0,01 In
    input wire logic [RATIO_W-1:0] dropout_ratio, // Drop-out ratio, 0,01 steps
    input wire logic [PU_DLY_W-1:0] pickup_delay_ms, // Pickup delay, ms
    input wire logic [TRIP_DLY_W-1:0] trip_delay_ms, // Trip delay, ms
    input wire logic [DO_DLY_W-1:0] dropout_delay_ms, // Drop-out delay, ms
    input wire logic cur_sup_en, // Current supervision enabled
    input wire logic [CUR_W-1:0] zero_level, // Zero level, 0,01 In
    input wire logic [REC_W-1:0] recovery_ms, // Recovery time, ms
    input wire logic [2:0] block_sel, // Pickup block source
    input wire logic [3:0] user_var, // User-defined variables 1..4
    input wire logic trip_relay_mapped, // Trip drives a trip relay
    input wire logic inrush_en, // Inrush restraint enabled
    input wire logic [PCT_W-1:0] inrush_pickup_pct, // Inrush pickup, percent
    input wire logic [CUR_W-1:0] inrush_max_cur, // Inrush max current, 0,01 In
    input wire logic counter_clear, // Clears all counters
    output logic pickup, // Pickup level
    output logic [2:0] phase_pickup, // Per-phase pickup level
    output logic trip, // Trip, pulse or level
    output logic operation_blocked, // Protection blocked
    output logic inrush_block, // Inrush restraint block level
    output logic [2:0] inrush_phase, // Per-phase inrush detection
    output logic [CNT_W-1:0] cnt_pickup, // Total pickup count
    output logic [CNT_W-1:0] cnt_trip, // Trip count
    output logic [2:0][CNT_W-1:0] cnt_phase, // Per-phase pickup counts
    output logic [CNT_W-1:0] cnt_inrush // Inrush event count
);

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int PROD_W = CUR_W + RATIO_W + 1;
    localparam int PULSE_W = $clog2(TRIP_PULSE_CYCLES + 1);

    inrush_link_if link ();

    logic [TICK_W-1:0] tick_cnt_reg;
    logic tick_reg;
    logic active;
    logic [2:0] cond_reg;
    logic ext_block;
    logic all_zero;
    logic zero_hold_reg;
    logic [REC_W-1:0] rec_cnt_reg;
    logic blocked;
    logic qual;
    logic pickup_reg;
    logic [PU_DLY_W-1:0] pu_cnt_reg;
    logic [DO_DLY_W-1:0] do_cnt_reg;
    logic trip_level_reg;
    logic [TRIP_DLY_W-1:0] tr_cnt_reg;
    logic trip_level_d_reg;
    logic [PULSE_W-1:0] pulse_cnt_reg;
    logic trip_reg;
    logic [2:0] phase_pickup_reg;
    logic pickup_d_reg;
    logic [2:0] phase_pickup_d_reg;
    logic blocked_reg;

    // One millisecond tick for every timer except the trip pulse
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_reg <= CNT_RST[TICK_W-1:0];
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= CNT_RST[TICK_W-1:0];
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    assign link.tick = tick_reg;

    // Function runs only when enabled and on in this group
    assign active = function_enable && operate_on;

    // Per-phase undercurrent with drop-out ratio hysteresis
    for (genvar p = 0; p < 3; p++) begin : g_cond
        logic [PROD_W-1:0] meas_scaled;
        logic [PROD_W-1:0] thr_scaled;
        assign meas_scaled = PROD_W'(phase_mag[p]) * PROD_W'(RATIO_ONE);
        assign thr_scaled = PROD_W'(pickup_thr) * PROD_W'(dropout_ratio);
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                cond_reg[p] <= 1'b0;
            end else if (!active) begin
                cond_reg[p] <= 1'b0;
            end else if (phase_mag[p] < pickup_thr) begin
                cond_reg[p] <= 1'b1;
            end else if (meas_scaled >= thr_scaled) begin
                cond_reg[p] <= 1'b0;
            end
        end
    end

    // External blocking source selection
    always_comb begin
        case (block_sel)
            BLK_VAR1: ext_block = user_var[0];
            BLK_VAR2: ext_block = user_var[1];
            BLK_VAR3: ext_block = user_var[2];
            BLK_VAR4: ext_block = user_var[3];
            default: ext_block = 1'b0;
        endcase
    end

    // Zero current: all three phases below the zero level
    assign all_zero = cur_sup_en && (phase_mag[0] < zero_level) &&
        (phase_mag[1] < zero_level) && (phase_mag[2] < zero_level);

    // Recovery hold after the zero level is left
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            zero_hold_reg <= 1'b0;
            rec_cnt_reg <= CNT_RST[REC_W-1:0];
        end else if (all_zero) begin
            zero_hold_reg <= 1'b1;
            rec_cnt_reg <= CNT_RST[REC_W-1:0];
        end else if (!cur_sup_en || (zero_hold_reg && (rec_cnt_reg >= recovery_ms))) begin
            zero_hold_reg <= 1'b0;
        end else if (zero_hold_reg && tick_reg) begin
            rec_cnt_reg <= rec_cnt_reg + 1'b1;
        end
    end

    assign blocked = !active || ext_block || all_zero || zero_hold_reg;
    assign qual = (cond_reg != 3'h0) && !blocked;

    // Pickup delay and drop-out delay
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pickup_reg <= 1'b0;
            pu_cnt_reg <= CNT_RST[PU_DLY_W-1:0];
            do_cnt_reg <= CNT_RST[DO_DLY_W-1:0];
        end else if (blocked) begin
            pickup_reg <= 1'b0;
            pu_cnt_reg <= CNT_RST[PU_DLY_W-1:0];
            do_cnt_reg <= CNT_RST[DO_DLY_W-1:0];
        end else if (!pickup_reg) begin
            do_cnt_reg <= CNT_RST[DO_DLY_W-1:0];
            if (!qual) begin
                pu_cnt_reg <= CNT_RST[PU_DLY_W-1:0];
            end else if (pu_cnt_reg >= pickup_delay_ms) begin
                pickup_reg <= 1'b1;
            end else if (tick_reg) begin
                pu_cnt_reg <= pu_cnt_reg + 1'b1;
            end
        end else begin
            if (qual) begin
                do_cnt_reg <= CNT_RST[DO_DLY_W-1:0];
            end else if (do_cnt_reg >= dropout_delay_ms) begin
                pickup_reg <= 1'b0;
                pu_cnt_reg <= CNT_RST[PU_DLY_W-1:0];
            end else if (tick_reg) begin
                do_cnt_reg <= do_cnt_reg + 1'b1;
            end
        end
    end

    // Trip delay, cleared whenever pickup drops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trip_level_reg <= 1'b0;
            tr_cnt_reg <= CNT_RST[TRIP_DLY_W-1:0];
        end else if (!pickup_reg) begin
            trip_level_reg <= 1'b0;
            tr_cnt_reg <= CNT_RST[TRIP_DLY_W-1:0];
        end else if (!trip_level_reg) begin
            if (tr_cnt_reg >= trip_delay_ms) begin
                trip_level_reg <= 1'b1;
            end else if (tick_reg) begin
                tr_cnt_reg <= tr_cnt_reg + 1'b1;
            end
        end
    end

    // Trip pulse of fixed width on each new trip
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trip_level_d_reg <= 1'b0;
            pulse_cnt_reg <= CNT_RST[PULSE_W-1:0];
        end else begin
            trip_level_d_reg <= trip_level_reg;
            if (!trip_level_reg) begin
                pulse_cnt_reg <= CNT_RST[PULSE_W-1:0];
            end else if (!trip_level_d_reg) begin
                pulse_cnt_reg <= PULSE_W'(TRIP_PULSE_CYCLES);
            end else if (pulse_cnt_reg != CNT_RST[PULSE_W-1:0]) begin
                pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
            end
        end
    end

    // Registered outputs: trip as pulse or level, phase pickups
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trip_reg <= 1'b0;
            phase_pickup_reg <= 3'h0;
            blocked_reg <= 1'b0;
        end else begin
            trip_reg <= trip_relay_mapped ? (pulse_cnt_reg != CNT_RST[PULSE_W-1:0])
                : trip_level_reg;
            phase_pickup_reg <= pickup_reg ? cond_reg : 3'h0;
            blocked_reg <= blocked;
        end
    end

    // Edge detection for the event counters
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pickup_d_reg <= 1'b0;
            phase_pickup_d_reg <= 3'h0;
        end else begin
            pickup_d_reg <= pickup_reg;
            phase_pickup_d_reg <= phase_pickup_reg;
        end
    end

    // Per-phase pickup counters
    for (genvar p = 0; p < 3; p++) begin : g_cnt
        event_counter #(.W(CNT_W)) u_cnt_phase (
            .clock(clock),
            .arst_n(arst_n),
            .clear(counter_clear),
            .inc(phase_pickup_reg[p] && !phase_pickup_d_reg[p]),
            .count(cnt_phase[p])
        );
    end

    // Total pickup, trip and inrush counters
    event_counter #(.W(CNT_W)) u_cnt_pickup (
        .clock(clock),
        .arst_n(arst_n),
        .clear(counter_clear),
        .inc(pickup_reg && !pickup_d_reg),
        .count(cnt_pickup)
    );

    event_counter #(.W(CNT_W)) u_cnt_trip (
        .clock(clock),
        .arst_n(arst_n),
        .clear(counter_clear),
        .inc(trip_level_reg && !trip_level_d_reg),
        .count(cnt_trip)
    );

    event_counter #(.W(CNT_W)) u_cnt_inrush (
        .clock(clock),
        .arst_n(arst_n),
        .clear(counter_clear),
        .inc(link.event_pulse),
        .count(cnt_inrush)
    );

    // Inrush restraint on the three phase currents
    inrush_detector u_inrush (
        .clock(clock),
        .arst_n(arst_n),
        .link(link),
        .phase_mag(phase_mag),
        .h2_pct(h2_pct),
        .enable(inrush_en),
        .pickup_pct(inrush_pickup_pct),
        .max_cur(inrush_max_cur)
    );

    assign pickup = pickup_reg;
    assign phase_pickup = phase_pickup_reg;
    assign trip = trip_reg;
    assign operation_blocked = blocked_reg;
    assign inrush_block = link.block;
    assign inrush_phase = link.phase_det;

endmodule

// ### src/uc_pkg.sv
// Shared constants for the undercurrent and inrush restraint block
package uc_pkg;

    // Clock rate and the one millisecond time base
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 1;
    localparam int CYCLES_PER_MS = (CLK_HZ / 1000) * TICK_MS;

    // Data widths: currents in 0,01 x rated current, ratios in 0,01 steps
    localparam int CUR_W = 16;
    localparam int RATIO_W = 9;
    localparam int PCT_W = 7;
    localparam int PU_DLY_W = 10;
    localparam int TRIP_DLY_W = 19;
    localparam int DO_DLY_W = 16;
    localparam int REC_W = 7;
    localparam int CNT_W_DEF = 16;

    // Scale of the drop-out ratio (1,00 equals this figure)
    localparam logic [6:0] RATIO_ONE = 7'h64;

    // Fixed inrush timing in milliseconds
    localparam int INRUSH_HOLD_MS = 200;
    localparam int INRUSH_MAX_MS = 5000;
    localparam int INR_HOLD_W = 8;
    localparam int INR_MAX_W = 13;

    // Trip pulse width in clock cycles when mapped to a trip relay
    localparam int TRIP_PULSE_DEF = 4;

    // Pickup block source selection
    localparam logic [2:0] BLK_NONE = 3'h0;
    localparam logic [2:0] BLK_VAR1 = 3'h1;
    localparam logic [2:0] BLK_VAR2 = 3'h2;
    localparam logic [2:0] BLK_VAR3 = 3'h3;
    localparam logic [2:0] BLK_VAR4 = 3'h4;

    // Reset value of every counter and timer
    localparam logic [31:0] CNT_RST = 32'h0;

endpackage

// ### src/inrush_link_if.sv
// Link between the protection core and the inrush detector
`timescale 1ns/1ps
interface inrush_link_if;
    logic tick;
    logic [2:0] phase_det;
    logic block;
    logic event_pulse;

    modport core (output tick, input phase_det, input block, input event_pulse);
    modport det (input tick, output phase_det, output block, output event_pulse);
endinterface

// ### src/event_counter.sv
// Saturating event counter with synchronous clear
`timescale 1ns/1ps
module event_counter import uc_pkg::*; #(
    parameter int W = CNT_W_DEF
) (
    input wire logic clock, // Function clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic clear, // Clears the count
    input wire logic inc, // One-cycle event pulse
    output logic [W-1:0] count // Current count
);

    // Count events, hold at all ones, clear on request
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count <= CNT_RST[W-1:0];
        end else if (clear) begin
            count <= CNT_RST[W-1:0];
        end else if (inc && (count != {W{1'b1}})) begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ### src/inrush_detector.sv
// Second-harmonic inrush detection with hold and maximum duration
`timescale 1ns/1ps
module inrush_detector import uc_pkg::*; (
    input wire logic clock, // Function clock
    input wire logic arst_n, // Asynchronous reset, active low
    inrush_link_if.det link, // Tick in, detection out
    input wire logic [2:0][CUR_W-1:0] phase_mag, // Fundamental magnitudes
    input wire logic [2:0][PCT_W-1:0] h2_pct, // Second harmonic in percent
    input wire logic enable, // Inrush restraint enabled
    input wire logic [PCT_W-1:0] pickup_pct, // Inrush pickup percentage
    input wire logic [CUR_W-1:0] max_cur // Maximum current setting
);

    logic [2:0] det_reg;
    logic [2:0][INR_HOLD_W-1:0] hold_reg;
    logic [INR_MAX_W-1:0] dur_reg;
    logic expired_reg;
    logic block_reg;
    logic event_reg;
    logic over_cur;

    // Any fundamental above the maximum current disables the blocking output
    assign over_cur = (phase_mag[0] > max_cur) || (phase_mag[1] > max_cur) ||
        (phase_mag[2] > max_cur);

    // Per-phase detection, held for the fixed drop-out time
    for (genvar p = 0; p < 3; p++) begin : g_phase
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                det_reg[p] <= 1'b0;
                hold_reg[p] <= CNT_RST[INR_HOLD_W-1:0];
            end else if (!enable) begin
                det_reg[p] <= 1'b0;
                hold_reg[p] <= CNT_RST[INR_HOLD_W-1:0];
            end else if (h2_pct[p] > pickup_pct) begin
                det_reg[p] <= 1'b1;
                hold_reg[p] <= CNT_RST[INR_HOLD_W-1:0];
            end else if (det_reg[p] && (hold_reg[p] >= INR_HOLD_W'(INRUSH_HOLD_MS))) begin
                det_reg[p] <= 1'b0;
            end else if (det_reg[p] && link.tick) begin
                hold_reg[p] <= hold_reg[p] + 1'b1;
            end
        end
    end

    // Maximum block duration, rearmed once all detections clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dur_reg <= CNT_RST[INR_MAX_W-1:0];
            expired_reg <= 1'b0;
        end else if (det_reg == 3'h0) begin
            dur_reg <= CNT_RST[INR_MAX_W-1:0];
            expired_reg <= 1'b0;
        end else if (dur_reg >= INR_MAX_W'(INRUSH_MAX_MS)) begin
            expired_reg <= 1'b1;
        end else if (link.tick) begin
            dur_reg <= dur_reg + 1'b1;
        end
    end

    // Blocking output and its rising-edge event
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            block_reg <= 1'b0;
            event_reg <= 1'b0;
        end else begin
            block_reg <= enable && (det_reg != 3'h0) && !expired_reg && !over_cur;
            event_reg <= enable && (det_reg != 3'h0) && !expired_reg && !over_cur &&
                !block_reg;
        end
    end

    assign link.phase_det = det_reg;
    assign link.block = block_reg;
    assign link.event_pulse = event_reg;

endmodule

// ### bench/uc_monitor.sv
// Port-level checker for the undercurrent and inrush restraint block
`timescale 1ns/1ps
module uc_monitor import uc_pkg::*; #(
    parameter int TICK_CYCLES = CYCLES_PER_MS,
    parameter int CNT_W = CNT_W_DEF,
    parameter int TRIP_PULSE_CYCLES = TRIP_PULSE_DEF
) (
    input wire logic clock, // Clock
    input wire logic arst_n, // Reset
    input wire logic [2:0][CUR_W-1:0] phase_mag, // Currents
    input wire logic function_enable, // Enable
    input wire logic operate_on, // Mode
    input wire logic cur_sup_en, // Supervision
    input wire logic [CUR_W-1:0] zero_level, // Zero level
    input wire logic [2:0] block_sel, // Block source
    input wire logic [3:0] user_var, // Variables
    input wire logic trip_relay_mapped, // Pulse mode
    input wire logic [CUR_W-1:0] inrush_max_cur, // Inrush limit
    input wire logic counter_clear, // Clear
    input wire logic pickup, // Pickup
    input wire logic trip, // Trip
    input wire logic operation_blocked, // Blocked
    input wire logic inrush_block, // Inrush block
    input wire logic [CNT_W-1:0] cnt_pickup, // Pickups
    input wire logic [CNT_W-1:0] cnt_trip, // Trips
    input wire logic [2:0][CNT_W-1:0] cnt_phase, // Phase pickups
    input wire logic [CNT_W-1:0] cnt_inrush // Inrush events
);
    logic [2:0] zero_lo;
    logic [2:0] over_max;
    logic all_zero;
    logic ext_blk;
    int trip_len;
    int blk_len;

    // Per-phase level comparisons
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            zero_lo[i] = phase_mag[i] < zero_level;
            over_max[i] = phase_mag[i] > inrush_max_cur;
        end
    end
    assign all_zero = cur_sup_en && &zero_lo;
    assign ext_blk = block_sel inside {BLK_VAR1, BLK_VAR2, BLK_VAR3, BLK_VAR4}
        && user_var[2'(block_sel - 3'h1)];

    // Lengths of the trip level and of the inrush block
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trip_len <= 0;
            blk_len <= 0;
        end else begin
            trip_len <= trip ? trip_len + 1 : 0;
            blk_len <= inrush_block ? blk_len + 1 : 0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence held3(s);
        s [*3];
    endsequence

    disabled_quiet_a: assert property (held3(!(function_enable && operate_on))
        |-> !pickup) else $error("Pickup while disabled");
    ext_block_a: assert property (held3(ext_blk) |-> !pickup)
        else $error("Pickup while user block set");
    zero_block_a: assert property (held3(all_zero)
        |-> operation_blocked && !pickup) else $error("Zero current not blocking");
    trip_pulse_a: assert property (trip && trip_relay_mapped
        |-> trip_len < TRIP_PULSE_CYCLES) else $error("Trip pulse too long");
    counter_clear_a: assert property (counter_clear |=> cnt_pickup == '0
        && cnt_trip == '0 && cnt_inrush == '0 && cnt_phase == '0) else $error("Clear failed");
    cnt_step_a: assert property ($changed(cnt_pickup) && !$past(counter_clear)
        |-> cnt_pickup == CNT_W'($past(cnt_pickup) + 1)) else $error("Pickup count jump");
    inrush_maxcur_a: assert property (held3(|over_max) |-> !inrush_block)
        else $error("Inrush block above max current");
    inrush_limit_a: assert property (inrush_block
        |-> blk_len < (INRUSH_MAX_MS + 2) * TICK_CYCLES) else $error("Inrush block too long");
endmodule

bind undercurrent_inrush_protection uc_monitor #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W),
    .TRIP_PULSE_CYCLES(TRIP_PULSE_CYCLES)) u_mon (.clock, .arst_n, .phase_mag,
    .function_enable, .operate_on, .cur_sup_en, .zero_level, .block_sel, .user_var,
    .trip_relay_mapped, .inrush_max_cur, .counter_clear, .pickup, .trip, .operation_blocked,
    .inrush_block, .cnt_pickup, .cnt_trip, .cnt_phase, .cnt_inrush);

// ### bench/front_end_model.sv
// Measurement front end model: phase magnitudes and harmonic ratios
`timescale 1ns/1ps
module front_end_model import uc_pkg::*; (
    input wire logic clock, // Clock
    input wire logic arst_n, // Reset
    input wire logic [2:0][CUR_W-1:0] mag_cmd, // Commanded currents
    input wire logic [2:0][PCT_W-1:0] h2_cmd, // Commanded harmonics
    output logic [2:0][CUR_W-1:0] phase_mag, // Measured currents
    output logic [2:0][PCT_W-1:0] h2_pct // Measured harmonics
);
    // One measurement update per clock, cleared in reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase_mag <= '0;
            h2_pct <= '0;
        end else begin
            phase_mag <= mag_cmd;
            h2_pct <= h2_cmd;
        end
    end
endmodule

// ### bench/undercurrent_inrush_protection_tb.sv
// Self-checking bench for the undercurrent and inrush restraint block
`timescale 1ns/1ps
module undercurrent_inrush_protection_tb import uc_pkg::*;;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0][CUR_W-1:0] mag_cmd = {3{16'h0064}};
    logic [2:0][PCT_W-1:0] h2_cmd = '0;
    logic [2:0][CUR_W-1:0] phase_mag;
    logic [2:0][PCT_W-1:0] h2_pct;
    logic function_enable = 1'b1;
    logic operate_on = 1'b1;
    logic cur_sup_en = 1'b0;
    logic trip_relay_mapped = 1'b1;
    logic inrush_en = 1'b1;
    logic counter_clear = 1'b0;
    logic [2:0] block_sel = BLK_NONE;
    logic [3:0] user_var = 4'h0;
    logic [CUR_W-1:0] pickup_thr = 16'h004B;
    logic [RATIO_W-1:0] dropout_ratio = 9'h078;
    logic [PU_DLY_W-1:0] pickup_delay_ms = 10'h00A;
    logic [TRIP_DLY_W-1:0] trip_delay_ms = 19'h00014;
    logic [DO_DLY_W-1:0] dropout_delay_ms = 16'h0005;
    logic [CUR_W-1:0] zero_level = 16'h000A;
    logic [REC_W-1:0] recovery_ms = 7'h05;
    logic [PCT_W-1:0] inrush_pickup_pct = 7'h0F;
    logic [CUR_W-1:0] inrush_max_cur = 16'h02EE;
    logic pickup, trip, operation_blocked, inrush_block;
    logic [2:0] phase_pickup, inrush_phase;
    logic [1:0] cnt_pickup, cnt_trip, cnt_inrush;
    logic [2:0][1:0] cnt_phase;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    front_end_model u_fe (.clock, .arst_n, .mag_cmd, .h2_cmd, .phase_mag, .h2_pct);
    undercurrent_inrush_protection #(.TICK_CYCLES(4), .CNT_W(2), .TRIP_PULSE_CYCLES(4)) u_dut (
        .clock, .arst_n, .phase_mag, .h2_pct, .function_enable, .operate_on, .pickup_thr,
        .dropout_ratio, .pickup_delay_ms, .trip_delay_ms, .dropout_delay_ms, .cur_sup_en,
        .zero_level, .recovery_ms, .block_sel, .user_var, .trip_relay_mapped, .inrush_en,
        .inrush_pickup_pct, .inrush_max_cur, .counter_clear, .pickup, .phase_pickup, .trip,
        .operation_blocked, .inrush_block, .inrush_phase, .cnt_pickup, .cnt_trip, .cnt_phase,
        .cnt_inrush);

    initial begin
        forever #25 clock = ~clock;
    end

    // Cut a hung run short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            $display("[ERR] %0t run timed out", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One phase low: delay, trip pulse, hysteresis, drop-out
    task automatic t_trip();
        int n;
        mag_cmd[1] = 16'h0032;
        step(34);
        chk(pickup, 1'b0);
        for (int i = 0; i < 20 && pickup !== 1'b1; i++) step(1);
        chk(pickup, 1'b1);
        step(3);
        chk(phase_pickup, 3'h2);
        step(67);
        chk(trip, 1'b0);
        for (int i = 0; i < 30 && trip !== 1'b1; i++) step(1);
        for (n = 0; n < 10 && trip === 1'b1; n++) step(1);
        chk(n, 4);
        chk({cnt_pickup, cnt_trip, cnt_phase[1]}, 6'h15);
        mag_cmd[1] = 16'h0055;
        step(60);
        chk({pickup, trip}, 2'h2);
        trip_relay_mapped = 1'b0;
        step(1);
        chk(trip, 1'b1);
        mag_cmd[1] = 16'h005F;
        step(12);
        chk(pickup, 1'b1);
        for (int i = 0; i < 20 && pickup !== 1'b0; i++) step(1);
        chk(pickup, 1'b0);
        mag_cmd[1] = 16'h0064;
        $display("t_trip done");
    endtask

    // All phases below zero level, then recovery hold
    task automatic t_zero();
        cur_sup_en = 1'b1;
        mag_cmd = {3{16'h0005}};
        step(60);
        chk({operation_blocked, pickup}, 2'h2);
        trip_relay_mapped = 1'b1;
        mag_cmd = {3{16'h0032}};
        step(12);
        chk(operation_blocked, 1'b1);
        for (int i = 0; i < 30 && operation_blocked !== 1'b0; i++) step(1);
        chk(operation_blocked, 1'b0);
        for (int i = 0; i < 60 && pickup !== 1'b1; i++) step(1);
        step(3);
        chk(phase_pickup, 3'h7);
        mag_cmd = {3{16'h0064}};
        for (int i = 0; i < 40 && pickup !== 1'b0; i++) step(1);
        $display("t_zero done");
    endtask

    // Each user variable and each disable, then release; counters saturate
    task automatic t_block();
        for (int k = 0; k < 6; k++) begin
            block_sel = k < 4 ? 3'(k + 1) : BLK_NONE;
            user_var = k < 4 ? 4'(1 << k) : 4'h0;
            function_enable = k != 4;
            operate_on = k != 5;
            mag_cmd[0] = 16'h0032;
            step(80);
            chk(pickup, 1'b0);
            block_sel = BLK_NONE;
            function_enable = 1'b1;
            operate_on = 1'b1;
            for (int i = 0; i < 60 && pickup !== 1'b1; i++) step(1);
            chk(pickup, 1'b1);
            mag_cmd[0] = 16'h0064;
            for (int i = 0; i < 40 && pickup !== 1'b0; i++) step(1);
        end
        chk({cnt_pickup, cnt_phase[0]}, 4'hF);
        counter_clear = 1'b1;
        step(1);
        counter_clear = 1'b0;
        chk({cnt_pickup, cnt_trip, cnt_phase}, 10'h000);
        $display("t_block done");
    endtask

    // Threshold, hold, max current and max duration of inrush
    task automatic t_inrush();
        h2_cmd[2] = 7'h0F;
        step(4);
        chk(inrush_phase, 3'h0);
        h2_cmd[2] = 7'h10;
        step(4);
        chk({inrush_phase, inrush_block, cnt_inrush}, 6'h25);
        h2_cmd[2] = 7'h00;
        step(700);
        chk(inrush_block, 1'b1);
        for (int i = 0; i < 150 && inrush_block !== 1'b0; i++) step(1);
        chk(inrush_block, 1'b0);
        h2_cmd[2] = 7'h10;
        mag_cmd[0] = 16'h0320;
        step(4);
        chk({inrush_phase, inrush_block}, 4'h8);
        mag_cmd[0] = 16'h0064;
        step(19000);
        chk({inrush_block, cnt_inrush}, 3'h6);
        for (int i = 0; i < 2000 && inrush_block !== 1'b0; i++) step(1);
        chk({inrush_phase, inrush_block}, 4'h8);
        inrush_en = 1'b0;
        step(3);
        chk(inrush_phase, 3'h0);
        $display("t_inrush done");
    endtask

    initial begin
        step(3);
        arst_n = 1'b1;
        step(2);
        t_trip();
        t_zero();
        t_block();
        t_inrush();
        finish_test();
    end
endmodule
